// File: rtl/gdio_port.sv
// general digital i/o port: latch, direction, pin sample, pull-up control
//
// Operation
// - direction one drives, zero makes input
// - input with latch one enables pull-up
// - reset tri-states all pins without clock
// - output pin drives the latch value
// - writing one to pin input toggles latch
// - three locations: latch, direction, pin input
// - pin input read-only; latch, direction read-write
// - global pull-up off suppresses every pull-up
// - pin level readable in any direction
// - input passes falling-edge flop then rising-edge flop synchroniser
// - external change seen after half to 1.5 periods
// - written level sampled one period after pin
// - single-bit set/clear leaves other bits alone
// - alternate pins leave other pins as gpio
`default_nettype none
module gdio_port
    import gdio_pkg::*;
#(
    parameter int W = GDIO_WIDTH,
    parameter int IW = $clog2(GDIO_WIDTH)
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [GDIO_ADDR_W-1:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [W-1:0] io_wdata_i,
    input wire logic bit_set_instr_i,
    input wire logic bit_clear_instr_i,
    input wire logic [IW-1:0] bit_idx_i,
    input wire logic global_pullup_off_i,
    input wire logic [W-1:0] alt_en_i,
    input wire logic [W-1:0] alt_dir_i,
    input wire logic [W-1:0] alt_out_i,
    input wire logic [W-1:0] pin_in_i,
    output logic [W-1:0] pin_out_o,
    output logic [W-1:0] pin_oe_n_o,
    output logic [W-1:0] pullup_en_o,
    output logic [W-1:0] io_rdata_o
);
    logic [W-1:0] output_latch_reg;
    logic [W-1:0] direction_reg;
    logic [W-1:0] next_latch;
    logic [W-1:0] next_dir;
    logic [W-1:0] next_rdata;
    logic [W-1:0] next_out;
    logic [W-1:0] next_oe_n;
    logic [W-1:0] next_pullup;
    logic [W-1:0] bit_mask;
    logic [W-1:0] pin_sample_bit;

    gdio_sync_if #(.W(W)) sif ();

    assign sif.pin_level = pin_in_i;
    assign sif.ce = ce_i;
    assign pin_sample_bit = sif.sample;

    gdio_pin_sync #(.W(W)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    assign bit_mask = {{(W-1){1'b0}}, 1'b1} << bit_idx_i;

    // register writes and single-bit operations
    always_comb begin
        next_latch = output_latch_reg;
        next_dir = direction_reg;
        if (io_wr_i) begin
            if (io_addr_i == GDIO_IDX_OUT_LATCH) begin
                next_latch = io_wdata_i;
            end else if (io_addr_i == GDIO_IDX_DIRECTION) begin
                next_dir = io_wdata_i;
            end else if (io_addr_i == GDIO_IDX_PIN_INPUT) begin
                // ones toggle, zeros leave the latch as it is
                next_latch = output_latch_reg ^ io_wdata_i;
            end
        end else if (bit_set_instr_i) begin
            // only the addressed bit moves
            if (io_addr_i == GDIO_IDX_OUT_LATCH) begin
                next_latch = output_latch_reg | bit_mask;
            end else if (io_addr_i == GDIO_IDX_DIRECTION) begin
                next_dir = direction_reg | bit_mask;
            end else if (io_addr_i == GDIO_IDX_PIN_INPUT) begin
                next_latch = output_latch_reg ^ bit_mask;
            end
        end else if (bit_clear_instr_i) begin
            if (io_addr_i == GDIO_IDX_OUT_LATCH) begin
                next_latch = output_latch_reg & ~bit_mask;
            end else if (io_addr_i == GDIO_IDX_DIRECTION) begin
                next_dir = direction_reg & ~bit_mask;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            output_latch_reg <= GDIO_RST_OUT_LATCH;
            direction_reg <= GDIO_RST_DIRECTION;
        end else if (ce_i) begin
            output_latch_reg <= next_latch;
            direction_reg <= next_dir;
        end
    end

    // read data; pin input shows the synchronised level
    always_comb begin
        next_rdata = io_rdata_o;
        if (io_rd_i) begin
            if (io_addr_i == GDIO_IDX_OUT_LATCH) begin
                next_rdata = output_latch_reg;
            end else if (io_addr_i == GDIO_IDX_DIRECTION) begin
                next_rdata = direction_reg;
            end else if (io_addr_i == GDIO_IDX_PIN_INPUT) begin
                next_rdata = pin_sample_bit;
            end else begin
                next_rdata = GDIO_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            io_rdata_o <= GDIO_UNMAPPED_READ;
        end else if (ce_i) begin
            io_rdata_o <= next_rdata;
        end
    end

    // pin drive; alternate pins take their own controls, others stay gpio
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (alt_en_i[i]) begin
                next_oe_n[i] = ~alt_dir_i[i];
                next_out[i] = alt_out_i[i];
                next_pullup[i] = 1'b0;
            end else begin
                next_oe_n[i] = ~direction_reg[i];
                next_out[i] = output_latch_reg[i];
                // pull-up only on inputs with latch one
                next_pullup[i] = ~direction_reg[i] & output_latch_reg[i]
                    & ~global_pullup_off_i;
            end
        end
    end

    // reset releases the pins at once, clock or not
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_oe_n_o <= '1;
            pin_out_o <= '0;
            pullup_en_o <= '0;
        end else if (ce_i) begin
            pin_oe_n_o <= next_oe_n;
            pin_out_o <= next_out;
            pullup_en_o <= next_pullup;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    dir_write_a: assert property (
        (io_wr_i && io_addr_i == GDIO_IDX_DIRECTION && alt_en_i == '0)
        ##1 (!io_wr_i && !bit_set_instr_i && !bit_clear_instr_i
             && alt_en_i == '0)
        |=> pin_oe_n_o == ~$past(io_wdata_i, 2))
        else $error("direction write not seen on output enable");

    pullup_out_a: assert property (
        (pullup_en_o & ~pin_oe_n_o) == '0)
        else $error("pull-up on while pin driven");

    reset_tri_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        rst_i |=> (&pin_oe_n_o && pullup_en_o == '0))
        else $error("pins not released by reset");

    drive_val_a: assert property (
        ((pin_out_o ^ $past(output_latch_reg)) & ~pin_oe_n_o
         & ~$past(alt_en_i)) == '0)
        else $error("driven pin differs from latch");

    pin_toggle_a: assert property (
        io_wr_i && io_addr_i == GDIO_IDX_PIN_INPUT
        |=> output_latch_reg == ($past(output_latch_reg) ^ $past(io_wdata_i)))
        else $error("pin input write did not toggle latch");

    latch_rdback_a: assert property (
        io_rd_i && io_addr_i == GDIO_IDX_OUT_LATCH
        |=> io_rdata_o == $past(output_latch_reg))
        else $error("latch read returned wrong value");

    pud_off_a: assert property (
        $past(global_pullup_off_i) |-> pullup_en_o == '0)
        else $error("pull-up on while globally off");

    sample_delay_a: assert property (
        !$past(rst_i) && $stable(ce_i)
        |-> pin_sample_bit == $past(pin_in_i, 1))
        else $error("pin sample not one period behind pin");

    bitset_a: assert property (
        !io_wr_i && bit_set_instr_i && io_addr_i == GDIO_IDX_DIRECTION
        |=> direction_reg == ($past(direction_reg) | $past(bit_mask)))
        else $error("bit set touched other direction bits");

    zero_write_a: assert property (
        io_wr_i && io_addr_i == GDIO_IDX_PIN_INPUT && io_wdata_i == '0
        |=> $stable(output_latch_reg) && $stable(direction_reg))
        else $error("zero write to pin input changed state");

    toggle_c: cover property (io_wr_i && io_addr_i == GDIO_IDX_PIN_INPUT
        && io_wdata_i != '0);
    pullup_c: cover property (pullup_en_o != '0);
    bitclr_c: cover property (bit_clear_instr_i && !io_wr_i);
    alt_c: cover property (alt_en_i != '0 && alt_en_i != '1);
endmodule
`default_nettype wire

// File: rtl/gdio_pkg.sv
// package: register indices, widths and reset values of the general i/o port
`default_nettype none
package gdio_pkg;
    localparam int GDIO_WIDTH = 8;
    localparam int GDIO_ADDR_W = 2;
    localparam logic [1:0] GDIO_IDX_PIN_INPUT = 2'h0;
    localparam logic [1:0] GDIO_IDX_DIRECTION = 2'h1;
    localparam logic [1:0] GDIO_IDX_OUT_LATCH = 2'h2;
    localparam logic [7:0] GDIO_RST_OUT_LATCH = 8'h00;
    localparam logic [7:0] GDIO_RST_DIRECTION = 8'h00;
    localparam logic [7:0] GDIO_RST_SAMPLE = 8'h00;
    localparam logic [7:0] GDIO_UNMAPPED_READ = 8'h00;
    // synchroniser delay from a posedge-timed pin change to the sample bit
    localparam int GDIO_SYNC_CYCLES = 1;
endpackage
`default_nettype wire

// File: rtl/gdio_sync_if.sv
// interface: pin levels in, synchronised samples out, between port and syncer
`default_nettype none
interface gdio_sync_if #(parameter int W = 8);
    logic [W-1:0] pin_level;
    logic [W-1:0] sample;
    logic ce;
    modport port (output pin_level, output ce, input sample);
    modport sync (input pin_level, input ce, output sample);
endinterface
`default_nettype wire

// File: rtl/gdio_pin_sync.sv
// per-pin input synchroniser: falling-edge catch then rising-edge sample bit
`default_nettype none
module gdio_pin_sync
    import gdio_pkg::*;
#(
    parameter int W = GDIO_WIDTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    gdio_sync_if.sync sif
);
    logic [W-1:0] catch_q;
    logic [W-1:0] sample_q;
    logic [W-1:0] next_catch;
    logic [W-1:0] next_sample;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // the catch stage takes the pin at the falling edge while ce is high
            always_comb begin
                next_catch[g] = sif.ce ? sif.pin_level[g] : catch_q[g];
                next_sample[g] = sif.ce ? catch_q[g] : sample_q[g];
            end
        end
    endgenerate

    // holds on the falling edge, like the transparent-high latch
    always_ff @(negedge clk_sys_i) begin
        if (rst_i) begin
            catch_q <= GDIO_RST_SAMPLE;
        end else begin
            catch_q <= next_catch;
        end
    end

    // loaded into the sample bit at the next rising edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sample_q <= GDIO_RST_SAMPLE;
        end else begin
            sample_q <= next_sample;
        end
    end

    assign sif.sample = sample_q;
endmodule
`default_nettype wire

// File: tb/gdio_pin_model.sv
// board model: resolves each pin from device drive, board drive and pull-up
`default_nettype none
module gdio_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] pin_oe_n_i,
    input wire logic [7:0] pullup_en_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flt = 8'h55;
    // a floating pin shows a pattern that changes every cycle
    always @(posedge clk_i) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n_i[i]) level_o[i] = pin_out_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pullup_en_i[i]) level_o[i] = 1'b1;
            else level_o[i] = flt[i];
        end
    end
endmodule
`default_nettype wire

// File: tb/general_digital_io_port_test.sv
// testbench: register accesses, pin checks and board drive of the port
`default_nettype none
`define CHK(n, e, a) chk(n, e, a)
module general_digital_io_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gdio_pkg::*;
    logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, bset = 0, bclr = 0;
    logic global_pullup_off = 0;
    logic [1:0] addr = 2'h0;
    logic [2:0] idx = 3'h0;
    logic [7:0] wd = 8'h00, aen = 8'h00, adir = 8'h00, aout = 8'h00;
    logic [7:0] een = 8'h70, eval = 8'h30, pin, pout, oe_n, pu, rdata;
    int miscompares = 0, total_checks = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    gdio_port DUT (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .io_addr_i(addr),
        .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd), .bit_set_instr_i(bset),
        .bit_clear_instr_i(bclr), .bit_idx_i(idx), .global_pullup_off_i(global_pullup_off),
        .alt_en_i(aen), .alt_dir_i(adir), .alt_out_i(aout), .pin_in_i(pin),
        .pin_out_o(pout), .pin_oe_n_o(oe_n), .pullup_en_o(pu),
        .io_rdata_o(rdata));
    gdio_pin_model board (.clk_i(clk), .pin_out_i(pout), .pin_oe_n_i(oe_n),
        .pullup_en_i(pu), .ext_en_i(een), .ext_val_i(eval), .level_o(pin));
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] a);
        total_checks++;
        if (a !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, a);
            miscompares++;
        end
    endtask
    task automatic wrr(logic [1:0] a, logic [7:0] d);
        @(posedge clk) begin addr <= a; wd <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rdc(string n, logic [1:0] a, logic [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 `CHK(n, e, rdata);
    endtask
    task automatic bop(logic [1:0] a, logic [2:0] i, logic s);
        @(posedge clk) begin addr <= a; idx <= i; bset <= s; bclr <= !s; end
        @(posedge clk) begin bset <= 1'b0; bclr <= 1'b0; end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 `CHK("oe_n in reset", 8'hff, oe_n);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc("dir reset", GDIO_IDX_DIRECTION, GDIO_RST_DIRECTION);
        rdc("latch reset", GDIO_IDX_OUT_LATCH, GDIO_RST_OUT_LATCH);
        wrr(GDIO_IDX_OUT_LATCH, 8'ha5);
        wrr(GDIO_IDX_DIRECTION, 8'h0f);
        settle();
        `CHK("oe_n", 8'hf0, oe_n);
        `CHK("pin_out", 8'h05, pout & 8'h0f);
        `CHK("pullup", 8'ha0, pu);
        rdc("pins", GDIO_IDX_PIN_INPUT, 8'hb5);
        @(posedge clk) eval <= 8'h40;
        rdc("pin change", GDIO_IDX_PIN_INPUT, 8'hc5);
        wrr(GDIO_IDX_PIN_INPUT, 8'h03);
        rdc("toggle", GDIO_IDX_OUT_LATCH, 8'ha6);
        wrr(GDIO_IDX_PIN_INPUT, 8'h00);
        rdc("zero write", GDIO_IDX_OUT_LATCH, 8'ha6);
        rdc("dir kept", GDIO_IDX_DIRECTION, 8'h0f);
        settle();
        rdc("pin not stored", GDIO_IDX_PIN_INPUT, 8'hc6);
        @(posedge clk) global_pullup_off <= 1'b1;
        settle();
        `CHK("pullup off", 8'h00, pu);
        @(posedge clk) global_pullup_off <= 1'b0;
        bop(GDIO_IDX_DIRECTION, 3'h7, 1'b1);
        rdc("bit set", GDIO_IDX_DIRECTION, 8'h8f);
        bop(GDIO_IDX_DIRECTION, 3'h0, 1'b0);
        rdc("bit clear", GDIO_IDX_DIRECTION, 8'h8e);
        rdc("latch kept", GDIO_IDX_OUT_LATCH, 8'ha6);
        // single-bit toggle through pin input, then single-bit latch clear
        bop(GDIO_IDX_PIN_INPUT, 3'h6, 1'b1);
        rdc("bit toggle", GDIO_IDX_OUT_LATCH, 8'he6);
        bop(GDIO_IDX_OUT_LATCH, 3'h6, 1'b0);
        rdc("latch clear", GDIO_IDX_OUT_LATCH, 8'ha6);
        rdc("dir not hit", GDIO_IDX_DIRECTION, 8'h8e);
        @(posedge clk) begin aen <= 8'h01; adir <= 8'h01; aout <= 8'h01; end
        settle();
        `CHK("alt oe_n", 8'h70, oe_n);
        `CHK("alt out", 8'h87, pout & 8'h8f);
        wrr(2'h3, 8'hff);
        rdc("unmapped", 2'h3, GDIO_UNMAPPED_READ);
        rdc("dir after unmapped", GDIO_IDX_DIRECTION, 8'h8e);
        test_done();
    end
endmodule
`default_nettype wire
